//--- rtl/lsd_pkg.sv
// Shared constants, field layout and types of the segment display data block.
package lsd_pkg;

  // Bus and array geometry.
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 8;
  localparam int NUM_BUF = 20;
  localparam int NUM_SEG = 40;
  localparam int NUM_COM = 4;
  localparam int CNT_W   = 19;

  // Register addresses, one byte register per address.
  localparam logic [ADDR_W-1:0] ADDR_BUF_FIRST = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_BUF_LAST  = 5'h13;
  localparam logic [ADDR_W-1:0] ADDR_DRV_EN    = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE  = 5'h15;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO  = 5'h16;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 5'h17;

  // Field positions.
  localparam int DRV_EN_BIT    = 0;
  localparam int DISP_EN_BIT   = 7;
  localparam int DUTY_LSB      = 4;
  localparam int FREQ_LSB      = 0;
  localparam int CONN_LSB      = 4;
  localparam int HISEL_BIT     = 0;
  localparam int INT_BLEED_BIT = 7;
  localparam int ST_RUN_BIT    = 7;
  localparam int ST_SW_BIT     = 6;
  localparam int ST_SUPPLY_BIT = 5;

  // Reset values.
  localparam logic [DATA_W-1:0] DRV_EN_RST   = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_ONE_RST = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_TWO_RST = 8'h00;
  localparam logic [DATA_W-1:0] BUF_RST      = 8'h00;

  // Connection-time codes of the low bleeder.
  localparam logic [2:0] CONN_FIRST  = 3'h1;
  localparam logic [2:0] CONN_LAST   = 3'h5;
  localparam logic [2:0] CONN_ALWAYS = 3'h6;
  localparam logic [2:0] CONN_SHIFT0 = 3'h6;

  // Base frequency codes and divider exponents.
  localparam logic [3:0] FREQ_HI_MAX   = 4'h4;
  localparam logic [3:0] FREQ_LOW_A    = 4'h8;
  localparam logic [3:0] FREQ_LOW_B    = 4'h9;
  localparam int         EXP_HI_DEF    = 18;
  localparam int         EXP_LOW_A_DEF = 9;
  localparam int         EXP_LOW_B_DEF = 8;
  localparam logic [4:0] SLOT_SHIFT    = 5'h02;

  // Drive methods.
  typedef enum logic [2:0] {
    DUTY_QUARTER  = 3'h0,
    DUTY_THIRD_B3 = 3'h1,
    DUTY_THIRD_B2 = 3'h2,
    DUTY_HALF     = 3'h3,
    DUTY_STATIC   = 3'h4
  } lsd_duty_t;

  // Scan sequencer states, Gray coded along idle, load, run.
  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_LOAD = 2'b01,
    SC_RUN  = 2'b11
  } lsd_scan_t;

  // Number of common phases that a drive method scans.
  function automatic logic [2:0] lsd_phases(input logic [2:0] duty);
    case (duty)
      DUTY_THIRD_B3: lsd_phases = 3'h3;
      DUTY_THIRD_B2: lsd_phases = 3'h3;
      DUTY_HALF:     lsd_phases = 3'h2;
      DUTY_STATIC:   lsd_phases = 3'h1;
      default:       lsd_phases = 3'h4;
    endcase
  endfunction

endpackage

//--- rtl/lsd_bleed_timer.sv
// Low bleeder switch timer driven from the common scan timebase.
`timescale 1ns/1ps
module lsd_bleed_timer
  import lsd_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Scan timebase.
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] pos,
  input  wire logic [CNT_W-1:0] plen,
  input  wire logic [2:0]       nph,
  // Setting and switch.
  input  wire logic [2:0]       code,
  output logic                  sw_on_reg
);

  logic [CNT_W+2:0] prod;
  logic [CNT_W-1:0] thr;
  logic [2:0]       shamt;
  logic             sw_on_next;

  // Each phase keeps the switch closed for its first part; the share of a phase
  // grows with the active phase count so the frame share follows both the code and that count.
  always_comb begin
    shamt      = CONN_SHIFT0 - code;
    prod       = (CNT_W+3)'(plen >> shamt) * (CNT_W+3)'(nph);
    thr        = prod[CNT_W+1:2];
    sw_on_next = 1'b0;
    if (run) begin
      if (code == CONN_ALWAYS) begin
        sw_on_next = 1'b1;
      end else if (code >= CONN_FIRST && code <= CONN_LAST) begin
        sw_on_next = (pos < thr);
      end
    end
  end

  // Closed means low and high resistances in parallel, open means high only.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_on_reg <= 1'b0;
    end else if (ce) begin
      sw_on_reg <= sw_on_next;
    end
  end

endmodule

//--- rtl/lsd_core.sv
// Segment display data buffer, common scan and bleeder timing.
// Notes on behaviour
// - Low bleeder switch closes for a code-set share of each frame; 110 always.
// - Bleeder alternates between parallel low-high and high-only timing states.
// - High bleeder select bit: 1 picks the higher, 0 the lower resistance.
// - Only the timed switch puts the low resistance in parallel.
// - Twenty byte buffer registers, all readable and writable.
// - Hardware scans the buffer; rewritten bytes show on following scans.
// - A buffer bit of 1 lights its pixel, 0 leaves it dark.
// - Reset clears all twenty buffer registers.
// - Byte n low nibble feeds segment 2n, high nibble segment 2n+1.
// - Drive method sets used bits per nibble: four, three, two or one.
// - Unused buffer bits and bytes keep what software wrote.
// - Reset drives commons low and releases shared segment pins.
// - Reset gives shared bleeder pins their external bleeder function.
// - Reset clears the display enable bit, blanking the display.
// - Clearing the driver enable blanks; setting it again restores display.
`timescale 1ns/1ps
module lsd_core
  import lsd_pkg::*;
#(
  parameter int EXP_HI    = EXP_HI_DEF,
  parameter int EXP_LOW_A = EXP_LOW_A_DEF,
  parameter int EXP_LOW_B = EXP_LOW_B_DEF
) (
  // Clock, reset and clock enable.
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data_reg,
  // Pin function selection from the port block.
  input  wire logic [NUM_SEG-1:0] port_function_select,
  // Waveform generator side.
  output logic [NUM_COM-1:0]     common_phase_reg,
  output logic [NUM_SEG-1:0]     segment_out_reg,
  output logic [NUM_SEG-1:0]     seg_oe_n_reg,
  output logic [2:0]             drive_method_reg,
  output logic [1:0]             phase_idx_reg,
  output logic                   frame_start_reg,
  // Analog controls.
  output logic                   lcd_supply_pin_on_reg,
  output logic                   low_bleed_sw_reg,
  output logic                   high_bleed_select_reg,
  output logic                   ext_bleed_func_reg
);

  // Display data storage.
  logic [DATA_W-1:0] seg_buffer [NUM_BUF];

  // Control registers.
  logic [DATA_W-1:0] driver_enable_reg;
  logic [DATA_W-1:0] display_ctrl_one_reg;
  logic [DATA_W-1:0] display_ctrl_two_reg;

  // Scan state.
  lsd_scan_t         scan_reg;
  lsd_scan_t         scan_next;
  logic [CNT_W-1:0]  pos_reg;
  logic [1:0]        phase_reg;
  logic [NUM_SEG-1:0] seg_next;

  // Decoded settings.
  logic              driver_enable_bit;
  logic              display_enable_bit;
  logic              disp_active;
  logic [2:0]        duty;
  logic [3:0]        base_freq_select;
  logic [2:0]        low_bleed_conn_time;
  logic [2:0]        nph;
  logic [4:0]        base_exp;
  logic [CNT_W-1:0]  plen;
  logic              phase_end;
  logic              frame_end;
  logic              running;
  logic [DATA_W-1:0] status_val;

  // True when the address falls in the display buffer.
  function automatic logic is_buf(input logic [ADDR_W-1:0] a);
    is_buf = (a >= ADDR_BUF_FIRST) && (a <= ADDR_BUF_LAST);
  endfunction

  // Buffer index for a buffer address.
  function automatic logic [4:0] buf_idx(input logic [ADDR_W-1:0] a);
    buf_idx = 5'(a - ADDR_BUF_FIRST);
  endfunction

  // Divider exponent of the base frequency; reserved codes take the slowest rate.
  function automatic logic [4:0] exp_of(input logic [3:0] f);
    if (f <= FREQ_HI_MAX) begin
      exp_of = 5'(EXP_HI) - 5'(f);
    end else if (f == FREQ_LOW_A) begin
      exp_of = 5'(EXP_LOW_A);
    end else if (f == FREQ_LOW_B) begin
      exp_of = 5'(EXP_LOW_B);
    end else begin
      exp_of = 5'(EXP_HI);
    end
  endfunction

  // Field extraction from the control registers.
  assign driver_enable_bit   = driver_enable_reg[DRV_EN_BIT];
  assign display_enable_bit  = display_ctrl_one_reg[DISP_EN_BIT];
  assign duty                = display_ctrl_one_reg[DUTY_LSB +: 3];
  assign base_freq_select    = display_ctrl_one_reg[FREQ_LSB +: 4];
  assign low_bleed_conn_time = display_ctrl_two_reg[CONN_LSB +: 3];
  assign disp_active         = driver_enable_bit & display_enable_bit;

  // Phase length: a quarter base period per phase, a whole one when static.
  always_comb begin
    nph      = lsd_phases(duty);
    base_exp = exp_of(base_freq_select);
    if (duty == DUTY_STATIC) begin
      plen = CNT_W'(1) << base_exp;
    end else begin
      plen = CNT_W'(1) << (base_exp - SLOT_SHIFT);
    end
    phase_end = (pos_reg >= plen - CNT_W'(1));
    frame_end = phase_end && ({1'b0, phase_reg} >= nph - 3'h1);
    running   = (scan_reg == SC_RUN);
  end

  // Buffer writes; the scan never alters a byte, so spare bits hold user data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        seg_buffer[i] <= BUF_RST;
      end
    end else if (ce && wr_en && is_buf(addr)) begin
      seg_buffer[buf_idx(addr)] <= wr_data;
    end
  end

  // Control register writes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      driver_enable_reg    <= DRV_EN_RST;
      display_ctrl_one_reg <= CTRL_ONE_RST;
      display_ctrl_two_reg <= CTRL_TWO_RST;
    end else if (ce && wr_en) begin
      case (addr)
        ADDR_DRV_EN:   driver_enable_reg    <= wr_data;
        ADDR_CTRL_ONE: display_ctrl_one_reg <= wr_data;
        ADDR_CTRL_TWO: display_ctrl_two_reg <= wr_data;
        default:       ;
      endcase
    end
  end

  // Status snapshot seen by software.
  always_comb begin
    status_val                = '0;
    status_val[ST_RUN_BIT]    = running;
    status_val[ST_SW_BIT]     = low_bleed_sw_reg;
    status_val[ST_SUPPLY_BIT] = lcd_supply_pin_on_reg;
    status_val[1:0]           = phase_reg;
  end

  // Read data stands in the cycle after the strobe only; unmapped reads give zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= '0;
    end else if (ce) begin
      if (!rd_en) begin
        rd_data_reg <= '0;
      end else if (is_buf(addr)) begin
        rd_data_reg <= seg_buffer[buf_idx(addr)];
      end else begin
        case (addr)
          ADDR_DRV_EN:   rd_data_reg <= driver_enable_reg;
          ADDR_CTRL_ONE: rd_data_reg <= display_ctrl_one_reg;
          ADDR_CTRL_TWO: rd_data_reg <= display_ctrl_two_reg;
          ADDR_STATUS:   rd_data_reg <= status_val;
          default:       rd_data_reg <= '0;
        endcase
      end
    end
  end

  // Scan sequencer: idle while blanked, one load cycle, then free running.
  always_comb begin
    case (scan_reg)
      SC_IDLE: scan_next = disp_active ? SC_LOAD : SC_IDLE;
      SC_LOAD: scan_next = disp_active ? SC_RUN : SC_IDLE;
      SC_RUN:  scan_next = disp_active ? SC_RUN : SC_IDLE;
      default: scan_next = SC_IDLE;
    endcase
  end

  // Sequencer state.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_reg <= SC_IDLE;
    end else if (ce) begin
      scan_reg <= scan_next;
    end
  end

  // Phase timebase; the position restarts at every phase and frame boundary.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_reg   <= '0;
      phase_reg <= 2'h0;
    end else if (ce) begin
      if (!running) begin
        pos_reg   <= '0;
        phase_reg <= 2'h0;
      end else if (frame_end) begin
        pos_reg   <= '0;
        phase_reg <= 2'h0;
      end else if (phase_end) begin
        pos_reg   <= '0;
        phase_reg <= phase_reg + 2'h1;
      end else begin
        pos_reg   <= pos_reg + CNT_W'(1);
      end
    end
  end

  // Segment data for the current phase, taken from both nibbles of every byte.
  generate
    for (genvar n = 0; n < NUM_BUF; n++) begin : g_seg
      assign seg_next[2*n]   = seg_buffer[n][phase_reg];
      assign seg_next[2*n+1] = seg_buffer[n][4 + phase_reg];
    end
  endgenerate

  // Waveform generator feed; after a drive method change mid-frame the current phase, even one above the new count, shows until it ends.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      segment_out_reg  <= '0;
      common_phase_reg <= '0;
      phase_idx_reg    <= 2'h0;
      frame_start_reg  <= 1'b0;
    end else if (ce) begin
      if (running) begin
        segment_out_reg  <= seg_next;
        common_phase_reg <= NUM_COM'(1) << phase_reg;
        phase_idx_reg    <= phase_reg;
        frame_start_reg  <= (pos_reg == '0) && (phase_reg == 2'h0);
      end else begin
        segment_out_reg  <= '0;
        common_phase_reg <= '0;
        phase_idx_reg    <= 2'h0;
        frame_start_reg  <= 1'b0;
      end
    end
  end

  // Pin functions and analog switches.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seg_oe_n_reg          <= '1;
      ext_bleed_func_reg    <= 1'b1;
      high_bleed_select_reg <= 1'b0;
      lcd_supply_pin_on_reg <= 1'b0;
      drive_method_reg      <= DUTY_QUARTER;
    end else if (ce) begin
      seg_oe_n_reg          <= ~port_function_select;
      ext_bleed_func_reg    <= ~display_ctrl_two_reg[INT_BLEED_BIT];
      high_bleed_select_reg <= display_ctrl_two_reg[HISEL_BIT];
      lcd_supply_pin_on_reg <= disp_active;
      drive_method_reg      <= duty;
    end
  end

  // Low bleeder switch timed from the scan position.
  lsd_bleed_timer u_bleed (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .run       (running),
    .pos       (pos_reg),
    .plen      (plen),
    .nph       (nph),
    .code      (low_bleed_conn_time),
    .sw_on_reg (low_bleed_sw_reg)
  );

endmodule

//--- test/lsd_core_properties.sv
// Concurrent checks on the ports of the segment display data block.
`timescale 1ns/1ps
module lsd_core_chk
  import lsd_pkg::*;
(
  // Clock and reset.
  input wire logic               clk,
  input wire logic               rst,
  // Register port.
  input wire logic               ce,
  input wire logic [ADDR_W-1:0]  addr,
  input wire logic [DATA_W-1:0]  wr_data,
  input wire logic               wr_en,
  input wire logic               rd_en,
  input wire logic [DATA_W-1:0]  rd_data_reg,
  // Pins and scan outputs.
  input wire logic [NUM_SEG-1:0] port_function_select,
  input wire logic [NUM_COM-1:0] common_phase_reg,
  input wire logic [NUM_SEG-1:0] seg_oe_n_reg,
  input wire logic [2:0]         drive_method_reg,
  input wire logic               frame_start_reg,
  input wire logic               lcd_supply_pin_on_reg,
  input wire logic               high_bleed_select_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Register writes that start a multi-cycle reaction.
  sequence s_drv_off;
    ce && wr_en && addr == ADDR_DRV_EN && !wr_data[DRV_EN_BIT];
  endsequence
  sequence s_ctrl_two_wr;
    ce && wr_en && addr == ADDR_CTRL_TWO;
  endsequence

  a_common_one_hot:
    assert property ($onehot0(common_phase_reg)) else $error("several commons active");
  a_drv_off_blank:
    assert property (s_drv_off |-> ##[1:3] (common_phase_reg == 4'h0 && !lcd_supply_pin_on_reg))
    else $error("display not blanked after driver disable");
  a_high_sel_follows:
    assert property (s_ctrl_two_wr |-> ##2 high_bleed_select_reg == $past(wr_data[HISEL_BIT], 2))
    else $error("high bleeder select does not follow its bit");
  a_seg_pin_enable:
    assert property (!$past(rst) && $past(ce) |-> seg_oe_n_reg == ~$past(port_function_select))
    else $error("segment pin enable does not follow pin selection");
  a_read_idle_zero:
    assert property (!$past(rd_en) |-> rd_data_reg == 8'h00) else $error("read data outside slot");
  a_frame_first_phase:
    assert property (frame_start_reg |-> common_phase_reg == 4'h1)
    else $error("frame does not start on first common");
  a_half_two_phases:
    assert property (drive_method_reg == DUTY_HALF && $past(drive_method_reg, 3) == DUTY_HALF
      |-> common_phase_reg[3:2] == 2'h0) else $error("half duty drives an unused common");
  a_static_one_phase:
    assert property (drive_method_reg == DUTY_STATIC && $past(drive_method_reg, 3) == DUTY_STATIC
      |-> common_phase_reg[3:1] == 3'h0) else $error("static drive uses an unused common");
endmodule

bind lsd_core lsd_core_chk i_chk (.clk, .rst, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data_reg,
  .port_function_select, .common_phase_reg, .seg_oe_n_reg, .drive_method_reg, .frame_start_reg,
  .lcd_supply_pin_on_reg, .high_bleed_select_reg);

//--- test/lsd_panel.sv
// Passive glass model that latches pixels and measures frame timing.
`timescale 1ns/1ps
module lsd_panel
  import lsd_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst,
  // Common and segment drive.
  input  wire logic [NUM_COM-1:0] com,
  input  wire logic [NUM_SEG-1:0] seg,
  input  wire logic               fs,
  input  wire logic               bleed,
  // Last complete frame length and bleeder on time.
  output logic      [15:0]        frame_len,
  output logic      [15:0]        frame_on
);
  logic [NUM_SEG-1:0] pix [NUM_COM];
  logic [15:0]        len_reg;
  logic [15:0]        on_reg;

  // Each pixel row takes the segment levels while its common is active.
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_COM; p++) begin
      if (com[p]) begin
        pix[p] <= seg;
      end
    end
  end

  // Counts cycles and bleeder on cycles from one frame start to the next.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      len_reg   <= 16'h0000;
      on_reg    <= 16'h0000;
      frame_len <= 16'h0000;
      frame_on  <= 16'h0000;
    end else begin
      len_reg <= fs ? 16'h0001 : len_reg + 16'h0001;
      on_reg  <= fs ? 16'(bleed) : on_reg + 16'(bleed);
      if (fs) begin
        frame_len <= len_reg;
        frame_on  <= on_reg;
      end
    end
  end
endmodule

//--- test/tb_top.sv
// Register level tests of the display data block with a passive panel.
`timescale 1ns/1ps
module tb_top;
  import lsd_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               ce = 1'b1;
  logic [ADDR_W-1:0]  addr = 5'h00;
  logic [DATA_W-1:0]  wr_data = 8'h00;
  logic               wr_en = 1'b0;
  logic               rd_en = 1'b0;
  logic [NUM_SEG-1:0] pfs = 40'h00FF00FF0F;
  logic [DATA_W-1:0]  rd_data_reg, val;
  logic [NUM_COM-1:0] com;
  logic [NUM_SEG-1:0] seg, oe_n, expv;
  logic               fs, sup, sw, hs, ext;
  logic [15:0]        flen, fon;
  logic [2:0]         dm;
  logic [1:0]         pidx;
  int                 n_errors = 0, compares = 0, nph, pl, on;

  lsd_core #(.EXP_HI(9), .EXP_LOW_A(4), .EXP_LOW_B(3)) i_dut (.clk, .rst, .ce, .addr, .wr_data,
    .wr_en, .rd_en, .rd_data_reg, .port_function_select(pfs), .common_phase_reg(com),
    .segment_out_reg(seg), .seg_oe_n_reg(oe_n), .drive_method_reg(dm), .phase_idx_reg(pidx),
    .frame_start_reg(fs), .lcd_supply_pin_on_reg(sup), .low_bleed_sw_reg(sw),
    .high_bleed_select_reg(hs), .ext_bleed_func_reg(ext));
  lsd_panel i_panel (.clk, .rst, .com, .seg, .fs, .bleed(sw), .frame_len(flen), .frame_on(fon));

  // Clock of 25 ns period.
  always #12.5 clk = ~clk;

  // Compares, bus cycles, frame waits and the verdict.
  task automatic check(input string nm, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check("read data", 40'(e), 40'(rd_data_reg));
  endtask
  task automatic frames(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (fs !== 1'b1 && k < 3000);
      if (fs !== 1'b1) begin
        n_errors++;
        $display("Error frame start expected 1 seen %b", fs);
      end
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog that cuts a hang short.
  initial begin
    #2_000_000;
    n_errors++;
    close_out();
  end

  // Main test sequence.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 24; a++) rd(ADDR_W'(a), 8'h00);
    for (int a = 0; a < 20; a++) begin
      wr(ADDR_W'(a), 8'(a * 37 + 5));
      rd(ADDR_W'(a), 8'(a * 37 + 5));
    end
    wr(5'h18, 8'hFF);
    rd(5'h18, 8'h00);
    rd(5'h1F, 8'h00);
    // A write while the clock enable is low must leave the buffer untouched.
    @(posedge clk);
    ce <= 1'b0;
    wr(ADDR_BUF_FIRST, 8'hAA);
    ce <= 1'b1;
    rd(ADDR_BUF_FIRST, 8'h05);
    check("segment enable", 40'(~pfs), 40'(oe_n));
    $display("register test done");
    for (int d = 0; d < 5; d++) begin
      for (int c = 0; c < 8; c++) begin
        nph = (d == 0) ? 4 : (d == 3) ? 2 : (d == 4) ? 1 : 3;
        pl = (d == 4) ? 512 : 128;
        // Bleeder share doubles per code from 1/32 of a frame, scaled by the phases over four.
        on = (c == 6) ? nph * pl : (c > 0 && c < 6) ? (nph * nph * pl << c) / 256 : 0;
        wr(ADDR_DRV_EN, 8'h01);
        wr(ADDR_CTRL_ONE, 8'(d << 4));
        wr(ADDR_CTRL_TWO, 8'(c << 4 | c % 2));
        for (int n = 0; n < 20; n++) wr(ADDR_W'(n), 8'(n * 29 + d * 83 + c * 7));
        wr(ADDR_CTRL_ONE, 8'(8'h80 | d << 4));
        frames(3);
        check("frame length", 40'(nph * pl), 40'(flen));
        check("bleeder on time", 40'(on), 40'(fon));
        check("high select", 40'(c % 2), 40'(hs));
        check("drive method", 40'(d), 40'(dm));
        check("frame phase index", 40'h0, 40'(pidx));
        check("frame first common", 40'h1, 40'(com));
        for (int p = 0; p < nph; p++) begin
          for (int s = 0; s < 40; s++) begin
            val = 8'(s / 2 * 29 + d * 83 + c * 7);
            expv[s] = val[s % 2 * 4 + p];
          end
          check("pixels", 40'(expv), 40'(i_panel.pix[p]));
        end
      end
      $display("drive method %0d test done", d);
    end
    wr(ADDR_DRV_EN, 8'h00);
    repeat (4) @(negedge clk);
    check("commons blanked", 40'h0, 40'(com));
    check("supply off", 40'h0, 40'(sup));
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_DRV_EN, 8'h01);
    frames(2);
    check("commons restored", 40'h1, 40'(com));
    check("supply on", 40'h1, 40'(sup));
    wr(ADDR_CTRL_TWO, 8'h81);
    repeat (2) @(negedge clk);
    check("internal bleeder pins", 40'h0, 40'(ext));
    check("high select set", 40'h1, 40'(hs));
    $display("driver enable test done");
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    check("reset commons", 40'h0, 40'(com));
    check("reset segment enable", {40{1'b1}}, 40'(oe_n));
    check("reset bleeder pins", 40'h1, 40'(ext));
    @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL_ONE, 8'h00);
    rd(ADDR_BUF_LAST, 8'h00);
    check("segment enable", 40'(~pfs), 40'(oe_n));
    check("supply after reset", 40'h0, 40'(sup));
    $display("reset test done");
    close_out();
  end
endmodule
